// File: hdl/swlm_core.sv
// swlm_core: double data rate burst sram with per-lane write masking.
// assumes K, K_n, C, C_n and all control pins come from outside the
// clk_sys_i domain; each half period of K spans at least 4 clk_sys_i
// cycles so every pin edge is seen after synchronisation.
`timescale 1ns/100ps
`include "swlm_defines.svh"

module swlm_core #(
  parameter int DATA_W = `SWLM_DATA_W,
  parameter int ADDR_W = `SWLM_ADDR_W
) (
  // clock and reset
  input  wire logic                  clk_sys_i,
  input  wire logic                  rst_n_i,
  // input and output clock pins
  input  wire logic                  k_i,
  input  wire logic                  k_n_i,
  input  wire logic                  c_i,
  input  wire logic                  c_n_i,
  // port selects, address, write beats
  input  wire logic                  write_port_select_n_i,
  input  wire logic                  read_port_select_n_i,
  input  wire logic [ADDR_W-1:0]     addr_i,
  input  wire logic [DATA_W-1:0]     d_i,
  input  wire logic [(DATA_W==36 ? 4 : 2)-1:0] byte_lane_enable_n_i,
  // read data pin, enable low while driven
  output logic      [DATA_W-1:0]     q_o,
  output logic                       q_oe_n_o,
  // strap state seen at reset release
  output logic                       single_clk_mode_o
);

  localparam int LANES = (DATA_W == 36) ? 4 : 2;         // nibble or byte lanes
  localparam int IDX_W = ADDR_W + 1;                     // word index with beat bit
  localparam int PIN_W = `SWLM_PIN_CTRL + ADDR_W + DATA_W + LANES;
  localparam int STRAP_CYC = `SWLM_STRAP_CYC;
  localparam logic [1:0] STRAP_LAST = 2'(STRAP_CYC);

  // ----------------------------------------
  // elaboration checks
  // ----------------------------------------
  if (!(DATA_W == 8 || DATA_W == 18 || DATA_W == 36)) begin : g_bad_width
    $error("data width must be 8, 18 or 36");
  end
  if (ADDR_W < 1 || ADDR_W > 20 || STRAP_CYC > 3) begin : g_bad_addr
    $error("address width or strap count out of range");
  end

  // ----------------------------------------
  // pin synchroniser
  // ----------------------------------------
  logic [PIN_W-1:0] pin_raw;  // all pins in one vector
  logic [PIN_W-1:0] meta_q;   // first stage, read by sync_q only
  logic [PIN_W-1:0] sync_q;   // second stage
  logic [3:0]       clk_prev_q; // last synchronised clock levels

  assign pin_raw = {byte_lane_enable_n_i, d_i, addr_i, read_port_select_n_i,
                    write_port_select_n_i, c_n_i, c_i, k_n_i, k_i};

  // two flops on every pin; idle as deselected
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_q <= '1;
      sync_q <= '1;
    end else begin
      meta_q <= pin_raw;
      sync_q <= meta_q;
    end
  end

  // clock levels one cycle back for edge finding
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      clk_prev_q <= 4'hf;
    end else begin
      clk_prev_q <= sync_q[3:0];
    end
  end

  logic [3:0]        clk_rise;  // rising edges of K, K_n, C, C_n
  logic              k_rise;
  logic              kn_rise;
  logic              oc_rise;   // output clock
  logic              ocn_rise;  // complementary output clock
  logic              wsel_n_s;
  logic              rsel_n_s;
  logic [ADDR_W-1:0] addr_s;
  logic [DATA_W-1:0] d_s;
  logic [LANES-1:0]  sel_s;
  logic              single_q;  // strap: C and C_n high at release

  assign clk_rise = sync_q[3:0] & ~clk_prev_q;
  assign k_rise   = clk_rise[`SWLM_PIN_K];
  assign kn_rise  = clk_rise[`SWLM_PIN_K_N];
  // single clock mode times the outputs from K and K_n
  assign oc_rise  = single_q ? k_rise  : clk_rise[`SWLM_PIN_C];
  assign ocn_rise = single_q ? kn_rise : clk_rise[`SWLM_PIN_C_N];
  assign wsel_n_s = sync_q[`SWLM_PIN_WSEL];
  assign rsel_n_s = sync_q[`SWLM_PIN_RSEL];
  assign addr_s   = sync_q[`SWLM_PIN_CTRL +: ADDR_W];
  assign d_s      = sync_q[`SWLM_PIN_CTRL + ADDR_W +: DATA_W];
  assign sel_s    = sync_q[`SWLM_PIN_CTRL + ADDR_W + DATA_W +: LANES];

  // ----------------------------------------
  // single clock strap
  // ----------------------------------------
  logic [1:0] strap_cnt_q;  // cycles since reset release
  logic       ready_q;      // strap caught, ports may start

  // wait for the synchroniser to fill, then catch C and C_n once
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      strap_cnt_q <= 2'h0;
      ready_q     <= 1'b0;
      single_q    <= 1'b0;
    end else if (!ready_q) begin
      strap_cnt_q <= strap_cnt_q + 2'h1;
      if (strap_cnt_q == STRAP_LAST) begin
        ready_q  <= 1'b1;
        single_q <= sync_q[`SWLM_PIN_C] & sync_q[`SWLM_PIN_C_N];
      end
    end
  end

  // ----------------------------------------
  // write port
  // ----------------------------------------
  swlm_pkg::swlm_wr_state_t wr_state_q;  // write sequence
  logic [ADDR_W-1:0] wr_addr_q;          // burst base address
  logic [DATA_W-1:0] d0_q;               // first beat
  logic [DATA_W-1:0] d1_q;               // second beat
  logic [LANES-1:0]  sel0_q;             // first beat selects
  logic [LANES-1:0]  sel1_q;             // second beat selects

  // select and beat 0 on K, address and beat 1 on K_n, then two commits
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_state_q <= swlm_pkg::WR_IDLE;
      wr_addr_q  <= '0;
      d0_q       <= '0;
      d1_q       <= '0;
      sel0_q     <= '1;
      sel1_q     <= '1;
    end else begin
      case (wr_state_q)
        swlm_pkg::WR_IDLE: begin
          // deselected: every input ignored
          if (ready_q && k_rise && !wsel_n_s) begin
            d0_q       <= d_s;
            sel0_q     <= sel_s;
            wr_state_q <= swlm_pkg::WR_BEAT1;
          end
        end
        swlm_pkg::WR_BEAT1: begin
          // pending write completes whatever the select does now
          if (kn_rise) begin
            wr_addr_q  <= addr_s;
            d1_q       <= d_s;
            sel1_q     <= sel_s;
            wr_state_q <= swlm_pkg::WR_COMMIT0;
          end
        end
        swlm_pkg::WR_COMMIT0: begin
          wr_state_q <= swlm_pkg::WR_COMMIT1;
        end
        default: begin
          wr_state_q <= swlm_pkg::WR_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // array access
  // ----------------------------------------
  logic              mem_wr_en;
  logic [IDX_W-1:0]  mem_wr_idx;
  logic [DATA_W-1:0] mem_wr_data;
  logic [LANES-1:0]  mem_sel;
  logic [IDX_W-1:0]  mem_rd_idx;
  logic [DATA_W-1:0] mem_rdata;
  logic              beat1_wr;  // second commit cycle

  swlm_pkg::swlm_rd_state_t rd_state_q;  // read sequence
  logic [ADDR_W-1:0]        rd_addr_q;   // read base address

  assign beat1_wr    = (wr_state_q == swlm_pkg::WR_COMMIT1);
  assign mem_wr_en   = (wr_state_q == swlm_pkg::WR_COMMIT0) || beat1_wr;
  assign mem_wr_idx  = {wr_addr_q, beat1_wr};
  assign mem_wr_data = beat1_wr ? d1_q : d0_q;
  assign mem_sel     = beat1_wr ? sel1_q : sel0_q;
  assign mem_rd_idx  = {rd_addr_q, rd_state_q == swlm_pkg::RD_BEAT1};

  swlm_lane_mem #(
    .DATA_W (DATA_W),
    .LANES  (LANES),
    .IDX_W  (IDX_W)
  ) u_mem (
    .clk_sys_i      (clk_sys_i),
    .rst_n_i        (rst_n_i),
    .wr_en_i        (mem_wr_en),
    .wr_idx_i       (mem_wr_idx),
    .wr_data_i      (mem_wr_data),
    .wr_lane_en_n_i (mem_sel),
    .rd_idx_i       (mem_rd_idx),
    .rd_data_o      (mem_rdata)
  );

  // ----------------------------------------
  // read port
  // ----------------------------------------
  logic [DATA_W-1:0] q_q;       // read data pin
  logic              q_oe_n_q;  // high while undriven

  // address on K, word 0 on C_n after the next K rise, word 1 on C, then release
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_state_q <= swlm_pkg::RD_IDLE;
      rd_addr_q  <= '0;
      q_q        <= '0;
      q_oe_n_q   <= 1'b1;
    end else begin
      case (rd_state_q)
        swlm_pkg::RD_IDLE: begin
          if (ready_q && k_rise && !rsel_n_s) begin
            rd_addr_q  <= addr_s;
            rd_state_q <= swlm_pkg::RD_WAIT_K;
          end
        end
        swlm_pkg::RD_WAIT_K: begin
          if (k_rise) begin
            rd_state_q <= swlm_pkg::RD_BEAT0;
          end
        end
        swlm_pkg::RD_BEAT0: begin
          if (ocn_rise) begin
            q_q        <= mem_rdata;
            q_oe_n_q   <= 1'b0;
            rd_state_q <= swlm_pkg::RD_BEAT1;
          end
        end
        swlm_pkg::RD_BEAT1: begin
          if (oc_rise) begin
            q_q        <= mem_rdata;
            rd_state_q <= swlm_pkg::RD_TAIL;
          end
        end
        default: begin
          // undriven after the next complementary output clock rise
          if (ocn_rise) begin
            q_oe_n_q   <= 1'b1;
            rd_state_q <= swlm_pkg::RD_IDLE;
          end
        end
      endcase
    end
  end

  assign q_o               = q_q;
  assign q_oe_n_o          = q_oe_n_q;
  assign single_clk_mode_o = single_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  chk_beat0_take: assert property (
    wr_state_q == swlm_pkg::WR_IDLE && ready_q && k_rise && !wsel_n_s |=>
      wr_state_q == swlm_pkg::WR_BEAT1 && d0_q == $past(d_s) && sel0_q == $past(sel_s))
    else $error("first beat not taken on K rise");

  chk_beat1_take: assert property (
    wr_state_q == swlm_pkg::WR_BEAT1 && kn_rise |=>
      d1_q == $past(d_s) && sel1_q == $past(sel_s) && wr_addr_q == $past(addr_s))
    else $error("second beat or address not taken on K_n rise");

  chk_burst_addr: assert property (
    wr_state_q == swlm_pkg::WR_COMMIT0 |->
      mem_wr_en && mem_wr_idx == {wr_addr_q, 1'b0} ##1
      mem_wr_en && mem_wr_idx[0] && mem_wr_idx[IDX_W-1:1] == $past(wr_addr_q))
    else $error("burst not written at A then A plus one");

  chk_beat_sel: assert property (
    wr_state_q == swlm_pkg::WR_COMMIT0 |->
      mem_sel == sel0_q && mem_wr_data == d0_q ##1
      mem_sel == sel1_q && mem_wr_data == d1_q)
    else $error("beat used the other beat's selects");

  chk_pend_finish: assert property (
    wr_state_q == swlm_pkg::WR_BEAT1 && kn_rise |=>
      wr_state_q == swlm_pkg::WR_COMMIT0 ##1 wr_state_q == swlm_pkg::WR_COMMIT1
      ##1 wr_state_q == swlm_pkg::WR_IDLE)
    else $error("pending write not completed");

  chk_desel_ignore: assert property (
    wr_state_q == swlm_pkg::WR_IDLE && !(k_rise && !wsel_n_s) |=>
      wr_state_q == swlm_pkg::WR_IDLE && !mem_wr_en)
    else $error("deselected write port acted");

  chk_idle_undriven: assert property (
    rd_state_q == swlm_pkg::RD_IDLE || rd_state_q == swlm_pkg::RD_WAIT_K |->
      q_oe_n_q)
    else $error("read data driven outside a read");

  chk_launch_edge: assert property (
    $fell(q_oe_n_q) |-> $past(ocn_rise) && $past(rd_state_q) == swlm_pkg::RD_BEAT0)
    else $error("read data launched off output clock");

  chk_second_word: assert property (
    rd_state_q == swlm_pkg::RD_BEAT1 && oc_rise |=>
      q_q == $past(mem_rdata) && rd_state_q == swlm_pkg::RD_TAIL && !q_oe_n_q)
    else $error("second word not launched on output clock");

endmodule

// File: hdl/swlm_defines.svh
// swlm_defines.svh: offsets, pin positions and timing counts of the
// write lane masking sram model.
// assumes inclusion by bare name from the design files.
`ifndef SWLM_DEFINES_SVH
`define SWLM_DEFINES_SVH

// default geometry
`define SWLM_DATA_W    18
`define SWLM_ADDR_W    6

// bit positions inside the synchronised pin vector
`define SWLM_PIN_K     0
`define SWLM_PIN_K_N   1
`define SWLM_PIN_C     2
`define SWLM_PIN_C_N   3
`define SWLM_PIN_WSEL  4
`define SWLM_PIN_RSEL  5
`define SWLM_PIN_CTRL  6

// strap settle time after reset release
`define SWLM_CLK_NS    10
`define SWLM_STRAP_NS  30
`define SWLM_STRAP_CYC ((`SWLM_STRAP_NS + `SWLM_CLK_NS - 1) / `SWLM_CLK_NS)

`endif

// File: hdl/swlm_pkg.sv
// swlm_pkg: state types of the write lane masking sram model.
// assumes nothing of its surroundings.
package swlm_pkg;

  // write port sequence
  typedef enum logic [1:0] {
    WR_IDLE,
    WR_BEAT1,
    WR_COMMIT0,
    WR_COMMIT1
  } swlm_wr_state_t;

  // read port sequence
  typedef enum logic [2:0] {
    RD_IDLE,
    RD_WAIT_K,
    RD_BEAT0,
    RD_BEAT1,
    RD_TAIL
  } swlm_rd_state_t;

endpackage

// File: hdl/swlm_lane_mem.sv
// swlm_lane_mem: storage array with per-lane masked write.
// assumes one write per cycle from swlm_core; read is combinational.
`timescale 1ns/100ps

module swlm_lane_mem #(
  parameter int DATA_W = 18,
  parameter int LANES  = 2,
  parameter int IDX_W  = 7
) (
  // clock and reset
  input  wire logic              clk_sys_i,
  input  wire logic              rst_n_i,
  // write side
  input  wire logic              wr_en_i,
  input  wire logic [IDX_W-1:0]  wr_idx_i,
  input  wire logic [DATA_W-1:0] wr_data_i,
  input  wire logic [LANES-1:0]  wr_lane_en_n_i,
  // read side
  input  wire logic [IDX_W-1:0]  rd_idx_i,
  output logic      [DATA_W-1:0] rd_data_o
);

  localparam int LW = DATA_W / LANES;   // bits per lane

  // lanes must split the word evenly
  if (DATA_W % LANES != 0) begin : g_bad_lanes
    $error("data width must split evenly into lanes");
  end

  logic [DATA_W-1:0] mem [2**IDX_W];    // word array
  logic [DATA_W-1:0] old_word;          // word before the write
  logic [DATA_W-1:0] merged;            // old and new lanes mixed

  assign old_word  = mem[wr_idx_i];
  assign rd_data_o = mem[rd_idx_i];

  // ----------------------------------------
  // lane merge
  // ----------------------------------------
  // low select takes the new lane, high select keeps the stored one
  for (genvar g = 0; g < LANES; g++) begin : g_lane
    assign merged[g*LW +: LW] = wr_lane_en_n_i[g] ? old_word[g*LW +: LW]
                                                  : wr_data_i[g*LW +: LW];
  end

  // whole word written back; all-high leaves it as it was
  always_ff @(posedge clk_sys_i) begin
    if (wr_en_i) begin
      mem[wr_idx_i] <= merged;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  logic              chk_en_q;   // a write happened last cycle
  logic [IDX_W-1:0]  chk_idx_q;  // its word index
  logic [DATA_W-1:0] chk_data_q; // its data
  logic [DATA_W-1:0] chk_old_q;  // the word before it
  logic [LANES-1:0]  chk_sel_q;  // its selects

  // remember the last write for the lane checks
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      chk_en_q   <= 1'b0;
      chk_idx_q  <= '0;
      chk_data_q <= '0;
      chk_old_q  <= '0;
      chk_sel_q  <= '1;
    end else begin
      chk_en_q   <= wr_en_i;
      chk_idx_q  <= wr_idx_i;
      chk_data_q <= wr_data_i;
      chk_old_q  <= old_word;
      chk_sel_q  <= wr_lane_en_n_i;
    end
  end

  for (genvar g = 0; g < LANES; g++) begin : g_chk
    chk_lane_write: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      chk_en_q && !chk_sel_q[g] |->
        mem[chk_idx_q][g*LW +: LW] == chk_data_q[g*LW +: LW])
      else $error("enabled lane not written");
    chk_lane_keep: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      chk_en_q && chk_sel_q[g] |->
        mem[chk_idx_q][g*LW +: LW] == chk_old_q[g*LW +: LW])
      else $error("masked lane altered");
  end

  chk_full_word: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    chk_en_q && (chk_sel_q == '0) |-> mem[chk_idx_q] == chk_data_q)
    else $error("full write lost bits");

endmodule

// File: sim/swlm_ctrl_model.sv
// swlm_ctrl_model: behavioural memory controller on the sram ports,
// making the input clock pair and driving write beats and reads.
// assumes clk_sys_i at 100 MHz and rst_n_i active low.
`timescale 1ns/100ps

module swlm_ctrl_model (
  // clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  // input clock pair
  output logic             k_o,
  output logic             k_n_o,
  // port selects, address, beats
  output logic             write_port_select_n_o,
  output logic             read_port_select_n_o,
  output logic [5:0]       addr_o,
  output logic [35:0]      d_o,
  output logic [3:0]       byte_lane_enable_n_o
);
  // --------------------------------------------------------------
  // input clock pair
  // --------------------------------------------------------------
  logic [3:0] phase_q;  // 16 clk per input clock period

  // free running phase counter
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phase_q <= 4'h0;
    end else begin
      phase_q <= phase_q + 4'h1;
    end
  end
  assign k_o   = (phase_q < 4'h8);  // high in phases 0..7
  // stopped pair held at equal levels in reset; rises at phase 8
  assign k_n_o = rst_n_i ? ~k_o : 1'b1;

  // idle levels at time zero
  initial begin
    write_port_select_n_o = 1'b1;
    read_port_select_n_o  = 1'b1;
    addr_o                = 6'h00;
    d_o                   = 36'h000000000;
    byte_lane_enable_n_o  = 4'hf;
  end

  // --------------------------------------------------------------
  // transfers
  // --------------------------------------------------------------
  // wait for the edge that moves the phase to ph
  task automatic wait_phase(input logic [3:0] ph);
    for (int i = 0; i < 17; i++) begin
      @(posedge clk_sys_i);
      if (phase_q == ph - 4'h1) return;
    end
    // phase never came round: counted as a mismatch
    sram_write_lane_masking_tb_top.err_total++;
    $display("[FAIL] %0t phase %0h never reached", $time, ph);
  endtask

  // beat0 held around K rise, beat1 around K_n rise
  task automatic drive_write(input logic [5:0] a, input logic [35:0] d0,
                             input logic [3:0] s0, input logic [35:0] d1,
                             input logic [3:0] s1, input logic ws_n);
    wait_phase(4'hc);
    write_port_select_n_o <= ws_n;
    d_o <= d0;
    byte_lane_enable_n_o <= s0;
    wait_phase(4'h4);
    write_port_select_n_o <= 1'b1;  // select only matters at K rise
    addr_o <= a;
    d_o <= d1;
    byte_lane_enable_n_o <= s1;
  endtask

  // read request around K rise; write data and lane enables inverted meanwhile
  task automatic drive_read(input logic [5:0] a);
    wait_phase(4'hc);
    read_port_select_n_o <= 1'b0;
    addr_o <= a;
    d_o <= ~d_o;
    byte_lane_enable_n_o <= ~byte_lane_enable_n_o;
    wait_phase(4'h4);
    read_port_select_n_o <= 1'b1;
    addr_o <= ~a;  // address no longer held
  endtask
endmodule

// File: sim/sram_write_lane_masking_tb_top.sv
// sram_write_lane_masking_tb_top: x8, x18 and x36 cores fed by one
// controller model, read data checked against a lane merge model.
// assumes swlm_core and swlm_ctrl_model compiled before it.
`timescale 1ns/100ps

module sram_write_lane_masking_tb_top;
  // --------------------------------------------------------------
  // signals
  // --------------------------------------------------------------
  typedef struct {
    logic [35:0] w0 [3];
    logic [35:0] w1 [3];
  } swlm_rd_exp_t;

  logic         clk_sys;
  logic         rst_n;
  logic         strap_c;   // high: output clocks tied high, single mode
  logic         k;
  logic         k_n;
  logic         wsel_n;
  logic         rsel_n;
  logic [5:0]   addr;
  logic [35:0]  d;
  logic [3:0]   lane_n;
  logic [7:0]   q8;
  logic [17:0]  q18;
  logic [35:0]  q36;
  logic [2:0]   oe_n;
  logic [2:0]   scm;
  int           wd [3] = '{8, 18, 36};
  logic [35:0]  ref_mem [3][128];   // expected array per width
  swlm_rd_exp_t exp_q [$];          // pending read results
  int           err_total = 0;
  int           compares = 0;
  int           seed;

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // --------------------------------------------------------------
  // instances
  // --------------------------------------------------------------
  swlm_ctrl_model i_swlm_ctrl_model (
    .clk_sys_i(clk_sys), .rst_n_i(rst_n), .k_o(k), .k_n_o(k_n),
    .write_port_select_n_o(wsel_n), .read_port_select_n_o(rsel_n),
    .addr_o(addr), .d_o(d), .byte_lane_enable_n_o(lane_n)
  );
  swlm_core #(.DATA_W(8)) i_swlm_core_8 (
    .clk_sys_i(clk_sys), .rst_n_i(rst_n), .k_i(k), .k_n_i(k_n), .c_i(strap_c | k),
    .c_n_i(strap_c | k_n), .write_port_select_n_i(wsel_n), .read_port_select_n_i(rsel_n),
    .addr_i(addr), .d_i(d[7:0]), .byte_lane_enable_n_i(lane_n[1:0]), .q_o(q8),
    .q_oe_n_o(oe_n[0]), .single_clk_mode_o(scm[0])
  );
  swlm_core #(.DATA_W(18)) i_swlm_core_18 (
    .clk_sys_i(clk_sys), .rst_n_i(rst_n), .k_i(k), .k_n_i(k_n), .c_i(strap_c | k),
    .c_n_i(strap_c | k_n), .write_port_select_n_i(wsel_n), .read_port_select_n_i(rsel_n),
    .addr_i(addr), .d_i(d[17:0]), .byte_lane_enable_n_i(lane_n[1:0]), .q_o(q18),
    .q_oe_n_o(oe_n[1]), .single_clk_mode_o(scm[1])
  );
  swlm_core #(.DATA_W(36)) i_swlm_core_36 (
    .clk_sys_i(clk_sys), .rst_n_i(rst_n), .k_i(k), .k_n_i(k_n), .c_i(strap_c | k),
    .c_n_i(strap_c | k_n), .write_port_select_n_i(wsel_n), .read_port_select_n_i(rsel_n),
    .addr_i(addr), .d_i(d), .byte_lane_enable_n_i(lane_n), .q_o(q36),
    .q_oe_n_o(oe_n[2]), .single_clk_mode_o(scm[2])
  );

  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  // lanes with select low take new data, others keep old
  function automatic logic [35:0] merge(input int w, input logic [35:0] old,
                                        input logic [35:0] nw, input logic [3:0] sel_n);
    logic [35:0] r;
    int          lw;
    int          nl;
    r  = old;
    lw = (w == 8) ? 4 : 9;
    nl = (w == 36) ? 4 : 2;
    for (int n = 0; n < nl; n++) begin
      if (!sel_n[n]) begin
        for (int b = 0; b < lw; b++) r[n * lw + b] = nw[n * lw + b];
      end
    end
    return r;
  endfunction

  task automatic check(input logic [35:0] got, input logic [35:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // random burst write; model array updated only when selected
  task automatic write_word(input logic [5:0] a, input logic [3:0] s0,
                            input logic [3:0] s1, input logic ws_n);
    logic [35:0] d0;
    logic [35:0] d1;
    d0 = {4'($urandom), $urandom};
    d1 = {4'($urandom), $urandom};
    i_swlm_ctrl_model.drive_write(a, d0, s0, d1, s1, ws_n);
    if (!ws_n) begin
      for (int k = 0; k < 3; k++) begin
        ref_mem[k][{a, 1'b0}] = merge(wd[k], ref_mem[k][{a, 1'b0}], d0, s0);
        ref_mem[k][{a, 1'b1}] = merge(wd[k], ref_mem[k][{a, 1'b1}], d1, s1);
      end
    end
  endtask

  // note the expected pair, then request the read
  task automatic read_word(input logic [5:0] a);
    swlm_rd_exp_t e;
    for (int k = 0; k < 3; k++) begin
      e.w0[k] = ref_mem[k][{a, 1'b0}];
      e.w1[k] = ref_mem[k][{a, 1'b1}];
    end
    exp_q.push_back(e);
    i_swlm_ctrl_model.drive_read(a);
    repeat (48) @(posedge clk_sys);
  endtask

  // --------------------------------------------------------------
  // result monitor: word0 at enable fall, word1 12 cycles on, released by 20
  // --------------------------------------------------------------
  initial begin
    swlm_rd_exp_t e;
    logic         oe_prev;
    oe_prev = 1'b1;
    forever begin
      @(negedge clk_sys);
      if (oe_prev === 1'b1 && oe_n[2] === 1'b0) begin
        if (exp_q.size() == 0) begin
          err_total++;
          $display("[FAIL] %0t read data without request", $time);
        end else begin
          e = exp_q.pop_front();
          check({33'h0, oe_n}, 36'h0, "enables word0");
          check({28'h0, q8}, {28'h0, e.w0[0][7:0]}, "x8 word0");
          check({18'h0, q18}, {18'h0, e.w0[1][17:0]}, "x18 word0");
          check(q36, e.w0[2], "x36 word0");
          repeat (12) @(negedge clk_sys);
          check({33'h0, oe_n}, 36'h0, "enables word1");
          check({28'h0, q8}, {28'h0, e.w1[0][7:0]}, "x8 word1");
          check({18'h0, q18}, {18'h0, e.w1[1][17:0]}, "x18 word1");
          check(q36, e.w1[2], "x36 word1");
          repeat (8) @(negedge clk_sys);
          check({33'h0, oe_n}, 36'h7, "released after word1");
        end
      end
      oe_prev = oe_n[2];
    end
  end

  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial begin
    rst_n   = 1'b0;
    strap_c = 1'b1;
    seed    = $urandom(82);
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (8) @(posedge clk_sys);
    check({33'h0, oe_n}, 36'h7, "outputs undriven");
    check({33'h0, scm}, 36'h7, "single clock strap");
    $display("test reset done");
    // full writes back to back, then reads
    for (int a = 0; a < 4; a++) write_word(6'(a), 4'h0, 4'h0, 1'b0);
    for (int a = 0; a < 4; a++) read_word(6'(a));
    $display("test full write done");
    // every select pattern on beat0, its inverse on beat1
    for (int s = 0; s < 16; s++) begin
      write_word(6'(16 + s), 4'h0, 4'h0, 1'b0);
      write_word(6'(16 + s), 4'(s), ~4'(s), 1'b0);
      read_word(6'(16 + s));
    end
    $display("test lane masks done");
    // write beats offered with the port deselected
    write_word(6'h01, 4'h0, 4'h0, 1'b1);
    read_word(6'h01);
    $display("test deselected write done");
    // second reset in mid-run, output clocks running: dual clock mode
    rst_n   <= 1'b0;
    strap_c <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (8) @(posedge clk_sys);
    check({33'h0, scm}, 36'h0, "dual clock strap");
    check({33'h0, oe_n}, 36'h7, "undriven after reset");
    write_word(6'h02, 4'($urandom), 4'($urandom), 1'b0);
    read_word(6'h02);
    $display("test dual clock done");
    for (int i = 0; i < 200 && exp_q.size() != 0; i++) @(posedge clk_sys);
    if (exp_q.size() != 0) begin
      err_total++;
      $display("[FAIL] %0t read results missing", $time);
    end
    end_of_test();
  end
endmodule
